/* File: rtl/ddsm_ctrl.v */
// dds mode control bank: first_function_control mode bits, second tuning word
// and the two sweep control words, reached over apb, with decoded mode outputs
// assumes pclk domain logic for segment_done and ramp_rate; pins are asynchronous
//
// What this block does
// - ram enable at 0 (reset) keeps the ram idle and selects single tone or sweep.
// - ram enable at 1 puts the ram in use under the current profile's segment word.
// - the ram destination bit has no effect while ram enable is clear.
// - with ram on, destination 0 feeds the tuning word path, 1 the phase offset path.
// - a nonzero internal profile field with ram on makes the active profile ignore profile pins and loop.
// - reload bit 0 reloads the amplitude ramp timer only when it reaches one.
// - reload bit 1 also reloads the amplitude ramp timer on an io update.
// - keying enable 0 bypasses shaped keying, 1 applies it to the amplitude.
// - the automatic keying bit has no effect while keying enable is clear.
// - with keying on, automatic bit 0 is manual keying and 1 is auto ramped.
// - the automatic sync bit at 1 enables multi-device sync, 0 disables it.
`timescale 1ns/1ns
`include "ddsm_map.vh"

module ddsm_ctrl #(
    parameter TMR_W = 8
) (
    input wire pclk, // apb clock, 50 mhz
    input wire presetn, // asynchronous reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, high for write
    input wire [7:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error for unmapped address
    input wire io_update_pin, // io update pin, asynchronous
    input wire [1:0] profile_pins, // external profile select pins, asynchronous
    input wire segment_done, // pulse from ram sequencer, next loop profile
    input wire [TMR_W-1:0] ramp_rate, // amplitude ramp rate reload value
    output reg ram_active, // ram in use
    output reg single_or_sweep, // ram idle, single tone or sweep mode
    output reg ram_to_freq, // ram output is the tuning word
    output reg ram_to_phase, // ram output is the phase offset word
    output reg [1:0] active_profile, // profile in effect
    output reg profile_loop, // internal profile loop running
    output reg keying_active, // shaped keying applied to amplitude
    output reg keying_manual, // manual keying
    output reg keying_auto, // automatically ramped keying
    output reg amp_tick, // one-cycle pulse on ramp timer timeout
    output reg auto_sync, // multi-device automatic sync enabled
    output reg [31:0] second_tuning_word, // second frequency tuning word
    output reg [31:0] sweep_delta, // selected delta frequency word
    output reg [7:0] sweep_rate // selected sweep ramp rate
);

    reg [31:0] ctrl_q;
    reg [31:0] tune2_q;
    reg [39:0] fall_q;
    reg [39:0] rise_q;
    reg upd_s1_q;
    reg upd_s2_q;
    reg upd_s3_q;
    reg [1:0] prof_s1_q;
    reg [1:0] prof_s2_q;
    reg [1:0] loop_q;
    reg [TMR_W-1:0] tmr_q;
    reg [31:0] rd_d;
    reg hit_d;
    reg [1:0] loop_d;
    reg [TMR_W-1:0] tmr_d;
    reg [31:0] status_d;
    reg ready_d;
    reg err_d;
    reg [31:0] rdata_d;
    reg [31:0] delta_d;
    reg [7:0] rate_d;

    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pready & pwrite;
    wire [5:0] idx = paddr[7:2];
    wire aligned = (paddr[1:0] == `DDSM_ALIGN_OK);
    // edge taken past the second flop, so only settled levels reach the timer
    wire upd_edge = upd_s2_q & ~upd_s3_q;

    wire ram_en = ctrl_q[`DDSM_CTRL_RAM_EN];
    wire [2:0] ipc = ctrl_q[`DDSM_CTRL_IPC_MSB:`DDSM_CTRL_IPC_LSB];
    wire loop_on = ram_en & (ipc != `DDSM_IPC_OFF);
    wire [1:0] loop_last = ipc[2] ? `DDSM_PROF_LAST : ipc[1:0];
    wire keying_en = ctrl_q[`DDSM_CTRL_KEY_EN];
    wire keying_auto_on = keying_en & ctrl_q[`DDSM_CTRL_KEY_AUTO];
    wire tmr_out = (tmr_q == `DDSM_TMR_TIMEOUT);
    wire tmr_reload = tmr_out | (ctrl_q[`DDSM_CTRL_RAMP_LOAD] & upd_edge);
    wire [1:0] prof_d = loop_on ? loop_d : prof_s2_q;

    // register read decode
    always @* begin
        rd_d = 32'h0000_0000;
        hit_d = aligned;
        case (idx)
            `DDSM_IDX_CTRL: begin
                rd_d = ctrl_q;
            end
            `DDSM_IDX_TUNE2: begin
                rd_d = tune2_q;
            end
            `DDSM_IDX_FALL: begin
                rd_d = fall_q[`DDSM_SW_DELTA_MSB:0];
            end
            `DDSM_IDX_RISE: begin
                rd_d = rise_q[`DDSM_SW_DELTA_MSB:0];
            end
            `DDSM_IDX_FALL_HI: begin
                rd_d = {24'h00_0000, fall_q[`DDSM_SW_RATE_MSB:`DDSM_SW_RATE_LSB]};
            end
            `DDSM_IDX_RISE_HI: begin
                rd_d = {24'h00_0000, rise_q[`DDSM_SW_RATE_MSB:`DDSM_SW_RATE_LSB]};
            end
            `DDSM_IDX_STATUS: begin
                rd_d = status_d;
            end
            default: begin
                hit_d = 1'b0;
            end
        endcase
    end

    // status word: read-only snapshot of the decoded modes and the ramp timer
    always @* begin
        status_d = `DDSM_RST_WORD;
        status_d[`DDSM_ST_RAM] = ram_active;
        status_d[`DDSM_ST_PHASE] = ram_to_phase;
        status_d[`DDSM_ST_KEY] = keying_active;
        status_d[`DDSM_ST_KEY_AUTO] = keying_auto;
        status_d[`DDSM_ST_SYNC] = auto_sync;
        status_d[`DDSM_ST_PROF_MSB:`DDSM_ST_PROF_LSB] = active_profile;
        status_d[`DDSM_ST_LOOP] = loop_on;
        status_d[`DDSM_ST_TMR_LSB +: TMR_W] = tmr_q;
    end

    // apb answer: ready one cycle after setup, read data only in that cycle
    always @* begin
        ready_d = 1'b0;
        err_d = 1'b0;
        rdata_d = `DDSM_RST_WORD;
        if (setup) begin
            ready_d = 1'b1;
            // unmapped or misaligned: error with zero data, write dropped
            err_d = ~hit_d;
            if (!pwrite && hit_d) begin
                rdata_d = rd_d;
            end
        end
    end

    // apb slave: ready one cycle after setup, write at the access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `DDSM_RST_WORD;
        end else begin
            pready <= ready_d;
            pslverr <= err_d;
            prdata <= rdata_d;
        end
    end

    // register writes; status and unmapped indices ignore writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `DDSM_RST_CTRL;
            tune2_q <= `DDSM_RST_WORD;
            fall_q <= `DDSM_RST_SWEEP;
            rise_q <= `DDSM_RST_SWEEP;
        end else if (wr_en && aligned) begin
            case (idx)
                `DDSM_IDX_CTRL: begin
                    ctrl_q <= pwdata & `DDSM_CTRL_MASK;
                end
                `DDSM_IDX_TUNE2: begin
                    tune2_q <= pwdata;
                end
                `DDSM_IDX_FALL: begin
                    fall_q[`DDSM_SW_DELTA_MSB:0] <= pwdata;
                end
                `DDSM_IDX_RISE: begin
                    rise_q[`DDSM_SW_DELTA_MSB:0] <= pwdata;
                end
                // high words keep only the rate byte; upper bits read back as zero
                `DDSM_IDX_FALL_HI: begin
                    fall_q[`DDSM_SW_RATE_MSB:`DDSM_SW_RATE_LSB] <= pwdata[7:0];
                end
                `DDSM_IDX_RISE_HI: begin
                    rise_q[`DDSM_SW_RATE_MSB:`DDSM_SW_RATE_LSB] <= pwdata[7:0];
                end
                `DDSM_IDX_STATUS: begin
                    // read-only; a write is dropped without an error
                    ctrl_q <= ctrl_q;
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // pin synchronisers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_s1_q <= 1'b0;
            upd_s2_q <= 1'b0;
            upd_s3_q <= 1'b0;
            prof_s1_q <= 2'h0;
            prof_s2_q <= 2'h0;
        end else begin
            upd_s1_q <= io_update_pin;
            upd_s2_q <= upd_s1_q;
            upd_s3_q <= upd_s2_q;
            prof_s1_q <= profile_pins;
            prof_s2_q <= prof_s1_q;
        end
    end

    // internal profile loop step
    always @* begin
        loop_d = loop_q;
        if (!loop_on) begin
            loop_d = `DDSM_PROF_FIRST;
        end else if (segment_done) begin
            // a counter already past the last index wraps too, so it never strands
            if (loop_q >= loop_last) begin
                loop_d = `DDSM_PROF_FIRST;
            end else begin
                loop_d = loop_q + `DDSM_PROF_STEP;
            end
        end
    end

    // amplitude ramp timer, runs only in auto ramped keying
    always @* begin
        tmr_d = tmr_q;
        if (!keying_auto_on) begin
            tmr_d = ramp_rate;
        end else if (tmr_reload) begin
            tmr_d = ramp_rate;
        end else if (tmr_q != `DDSM_TMR_ZERO) begin
            tmr_d = tmr_q - `DDSM_TMR_STEP;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_q <= `DDSM_PROF_FIRST;
            tmr_q <= `DDSM_TMR_ZERO;
            amp_tick <= 1'b0;
        end else begin
            loop_q <= loop_d;
            tmr_q <= tmr_d;
            // rate 1 holds the timer at one, so the tick then fires every cycle
            amp_tick <= keying_auto_on & tmr_out;
        end
    end

    // sweep word picked by the synchronised profile low bit
    always @* begin
        delta_d = fall_q[`DDSM_SW_DELTA_MSB:0];
        rate_d = fall_q[`DDSM_SW_RATE_MSB:`DDSM_SW_RATE_LSB];
        if (prof_s2_q[0]) begin
            delta_d = rise_q[`DDSM_SW_DELTA_MSB:0];
            rate_d = rise_q[`DDSM_SW_RATE_MSB:`DDSM_SW_RATE_LSB];
        end
    end

    // decoded mode outputs; each lags a register write by one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_active <= 1'b0;
            single_or_sweep <= 1'b1;
            ram_to_freq <= 1'b0;
            ram_to_phase <= 1'b0;
            active_profile <= 2'h0;
            profile_loop <= 1'b0;
            keying_active <= 1'b0;
            keying_manual <= 1'b0;
            keying_auto <= 1'b0;
            auto_sync <= 1'b0;
            second_tuning_word <= `DDSM_RST_WORD;
            sweep_delta <= `DDSM_RST_WORD;
            sweep_rate <= 8'h00;
        end else begin
            ram_active <= ram_en;
            single_or_sweep <= ~ram_en;
            ram_to_freq <= ram_en & ~ctrl_q[`DDSM_CTRL_RAM_DEST];
            ram_to_phase <= ram_en & ctrl_q[`DDSM_CTRL_RAM_DEST];
            active_profile <= prof_d;
            profile_loop <= loop_on;
            keying_active <= keying_en;
            keying_manual <= keying_en & ~ctrl_q[`DDSM_CTRL_KEY_AUTO];
            keying_auto <= keying_auto_on;
            auto_sync <= ctrl_q[`DDSM_CTRL_AUTO_SYNC];
            second_tuning_word <= tune2_q;
            sweep_delta <= delta_d;
            sweep_rate <= rate_d;
        end
    end

endmodule // ddsm_ctrl

/* File: rtl/ddsm_map.vh */
// register map, field positions and reset values of the dds mode control bank
// included by the control bank module; definitions only
`ifndef DDSM_MAP_VH
`define DDSM_MAP_VH

// register indices, byte address is four times the index
`define DDSM_IDX_CTRL 6'h00
`define DDSM_IDX_TUNE2 6'h06
`define DDSM_IDX_FALL 6'h07
`define DDSM_IDX_RISE 6'h08
`define DDSM_IDX_FALL_HI 6'h10
`define DDSM_IDX_RISE_HI 6'h11
`define DDSM_IDX_STATUS 6'h12

// first_function_control fields
`define DDSM_CTRL_RAM_EN 31
`define DDSM_CTRL_RAM_DEST 30
`define DDSM_CTRL_IPC_MSB 29
`define DDSM_CTRL_IPC_LSB 27
`define DDSM_CTRL_RAMP_LOAD 26
`define DDSM_CTRL_KEY_EN 25
`define DDSM_CTRL_KEY_AUTO 24
`define DDSM_CTRL_AUTO_SYNC 23
`define DDSM_CTRL_MASK 32'hFF80_0000

// sweep control word fields
`define DDSM_SW_DELTA_MSB 31
`define DDSM_SW_RATE_MSB 39
`define DDSM_SW_RATE_LSB 32

// status word fields
`define DDSM_ST_RAM 0
`define DDSM_ST_PHASE 1
`define DDSM_ST_KEY 2
`define DDSM_ST_KEY_AUTO 3
`define DDSM_ST_SYNC 4
`define DDSM_ST_PROF_LSB 5
`define DDSM_ST_PROF_MSB 6
`define DDSM_ST_LOOP 7
`define DDSM_ST_TMR_LSB 8

// word alignment of the byte address
`define DDSM_ALIGN_OK 2'h0

// reset values
`define DDSM_RST_CTRL 32'h0000_0000
`define DDSM_RST_WORD 32'h0000_0000
`define DDSM_RST_SWEEP 40'h00_0000_0000

// amplitude ramp timer
`define DDSM_TMR_TIMEOUT 8'h01
`define DDSM_TMR_ZERO 8'h00
`define DDSM_TMR_STEP 8'h01

// profile loop
`define DDSM_IPC_OFF 3'h0
`define DDSM_PROF_LAST 2'h3
`define DDSM_PROF_FIRST 2'h0
`define DDSM_PROF_STEP 2'h1

`endif

/* File: verification/ddsm_ctrl_checker.sv */
// checker for the dds mode control bank: decoded mode outputs and apb answer
// bound to ddsm_ctrl, sees only its ports, single pclk domain
`timescale 1ns/1ns
module ddsm_ctrl_checker (
    input wire pclk, // clock
    input wire presetn, // reset, active low
    input wire psel, // apb select
    input wire penable, // apb access
    input wire pwrite, // apb write
    input wire [7:0] paddr, // apb address
    input wire [31:0] pwdata, // apb write data
    input wire pready, // apb ready
    input wire ram_active, // ram in use
    input wire single_or_sweep, // ram idle
    input wire ram_to_freq, // ram to tuning word
    input wire ram_to_phase, // ram to phase offset
    input wire profile_loop, // internal loop
    input wire keying_active, // keying on
    input wire keying_manual, // manual keying
    input wire keying_auto, // auto keying
    input wire auto_sync // auto sync
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire ctrl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
    property p_ram_en; ctrl_wr |-> ##2 ram_active == $past(pwdata[31], 2); endproperty
    a_ram_en: assert property (p_ram_en) else $error("ram enable not applied");
    property p_mode_excl; single_or_sweep != ram_active; endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("ram and tone mode clash");
    property p_dest_off; !ram_active |-> !(ram_to_freq || ram_to_phase); endproperty
    a_dest_off: assert property (p_dest_off) else $error("destination used with ram off");
    property p_dest_sel;
        ctrl_wr |-> ##2 ram_to_phase == ($past(pwdata[31], 2) && $past(pwdata[30], 2));
    endproperty
    a_dest_sel: assert property (p_dest_sel) else $error("ram destination wrong");
    property p_loop;
        ctrl_wr |-> ##2 profile_loop == ($past(pwdata[31], 2) && $past(pwdata[29:27], 2) != 3'h0);
    endproperty
    a_loop: assert property (p_loop) else $error("profile loop state wrong");
    property p_key_en; ctrl_wr |-> ##2 keying_active == $past(pwdata[25], 2); endproperty
    a_key_en: assert property (p_key_en) else $error("keying enable wrong");
    property p_key_off; !keying_active |-> !keying_manual && !keying_auto; endproperty
    a_key_off: assert property (p_key_off) else $error("keying mode with keying off");
    property p_key_sel; keying_active |-> keying_manual != keying_auto; endproperty
    a_key_sel: assert property (p_key_sel) else $error("keying mode not unique");
    property p_sync; ctrl_wr ##1 1'b1 |=> auto_sync == $past(pwdata[23], 2); endproperty
    a_sync: assert property (p_sync) else $error("auto sync bit wrong");
    property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("ready pulse wrong");
endmodule // ddsm_ctrl_checker

bind ddsm_ctrl ddsm_ctrl_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .ram_active, .single_or_sweep, .ram_to_freq, .ram_to_phase,
    .profile_loop, .keying_active, .keying_manual, .keying_auto, .auto_sync);

/* File: verification/tb_ddsm_ctrl.sv */
// self-checking bench for the dds mode control bank
// drives apb, pins and ramp inputs directly; checker is bound to the design
`timescale 1ns/1ns
module tb_ddsm_ctrl;
    logic pclk, presetn, psel, penable, pwrite, io_update_pin, segment_done, err;
    logic [7:0] paddr, ramp_rate;
    logic [31:0] pwdata, rd, v, fl, fh, rl, rh;
    logic [1:0] profile_pins;
    wire [31:0] prdata, second_tuning_word, sweep_delta;
    wire [7:0] sweep_rate;
    wire [1:0] active_profile;
    wire pready, pslverr, ram_active, single_or_sweep, ram_to_freq, ram_to_phase;
    wire profile_loop, keying_active, keying_manual, keying_auto, amp_tick, auto_sync;
    wire [8:0] outs = {ram_active, single_or_sweep, ram_to_freq, ram_to_phase, profile_loop,
        keying_active, keying_manual, keying_auto, auto_sync};
    int fails, check_count, cyc;
    logic [31:0] n;
    logic [7:0] u_regs [6] = '{8'h00, 8'h18, 8'h1C, 8'h20, 8'h40, 8'h44};

    ddsm_ctrl #(.TMR_W(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .io_update_pin, .profile_pins, .segment_done, .ramp_rate,
        .ram_active, .single_or_sweep, .ram_to_freq, .ram_to_phase, .active_profile,
        .profile_loop, .keying_active, .keying_manual, .keying_auto, .amp_tick, .auto_sync,
        .second_tuning_word, .sweep_delta, .sweep_rate);

    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            give_verdict;
        end
    end

    function [8:0] mode(input [31:0] c);
        mode = {c[31], !c[31], c[31] & !c[30], c[31] & c[30], c[31] && c[29:27] != 3'h0,
            c[25], c[25] & !c[24], c[25] & c[24], c[23]};
    endfunction

    task chk(input [39:0] got, input [39:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input w, input [7:0] a, input [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    task rchk(input [7:0] a, input [31:0] exp, input e);
        apb(1'b0, a, 32'h0, rd, err);
        chk({err, rd}, {e, exp});
    endtask

    // io update pin rises every four cycles while amplitude ticks are counted
    task ticks(output logic [31:0] c);
        c = 0;
        for (int j = 0; j < 52; j++) begin
            @(posedge pclk);
            io_update_pin <= j[1];
            if (j >= 12) c += amp_tick;
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, io_update_pin, segment_done, presetn} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        ramp_rate = 8'h05;
        profile_pins = 2'h0;
        v = $urandom(32'h25F7_D964);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk(outs, mode(32'h0));
        foreach (u_regs[i]) rchk(u_regs[i], 32'h0, 1'b0);
        for (int i = 0; i < 20; i++) begin
            v = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h4100_0000 : $urandom;
            wr(8'h00, v);
            rchk(8'h00, v & 32'hFF80_0000, 1'b0);
            #1 chk(outs, mode(v));
        end
        {fl, fh, rl, rh} = {$urandom, $urandom, $urandom, $urandom};
        wr(8'h18, v);
        wr(8'h1C, fl);
        wr(8'h40, fh);
        wr(8'h20, rl);
        wr(8'h44, rh);
        rchk(8'h40, {24'h0, fh[7:0]}, 1'b0);
        for (int p = 0; p < 2; p++) begin
            @(posedge pclk);
            profile_pins <= 2'(p);
            repeat (5) @(posedge pclk);
            #1 chk({sweep_rate, sweep_delta}, p ? {rh[7:0], rl} : {fh[7:0], fl});
        end
        rchk(8'h4C, 32'h0, 1'b1);
        wr(8'h19, ~v);
        rchk(8'h18, v, 1'b0);
        chk(second_tuning_word, v);
        profile_pins <= 2'h2;
        wr(8'h00, 32'h9800_0000);
        for (int k = 1; k < 6; k++) begin
            @(posedge pclk);
            segment_done <= 1'b1;
            @(posedge pclk);
            segment_done <= 1'b0;
            repeat (2) @(posedge pclk);
            #1 chk(active_profile, 40'(k % 4));
        end
        wr(8'h00, 32'h0300_0000);
        ticks(n);
        chk(n, 8);
        wr(8'h00, 32'h0700_0000);
        ticks(n);
        chk(n, 0);
        wr(8'h00, 32'h0200_0000);
        ticks(n);
        chk(n, 0);
        chk(active_profile, 2'h2);
        rchk(8'h48, 32'h0000_0544, 1'b0);
        give_verdict;
    end
endmodule // tb_ddsm_ctrl
